//--- gcbf_guest_control_block_fields.sv
`timescale 1ns/100ps
module gcbf_guest_control_block_fields #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DATA_W = 64
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic guest_entry_in,
  input wire logic guest_exit_in,
  input wire gcbf_pkg::gcbf_exit_rec_t exit_rec_in,
  input wire logic ts_read_in,
  input wire logic [63:0] ts_counter_in,
  output logic [63:0] ts_value_out,
  output logic ts_valid_out,
  output logic guest_running_out,
  output logic [63:0] io_permission_map_out,
  output logic [63:0] msr_permission_map_out,
  output gcbf_pkg::gcbf_flush_t flush_out,
  output gcbf_pkg::gcbf_vint_t vint_out,
  output logic vint_deliver_out,
  output logic shadow_out,
  output logic nested_paging_on_out,
  output logic crypt_on_out,
  output logic [15:0] pause_count_out
);

  if (DATA_W != 64 || ADDR_W < 8) begin : g_bad_params
    $error("gcbf: DATA_W must be 64 and ADDR_W at least 8");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [4:0] gcbf_decode(input logic [ADDR_W-1:0] a);
    logic [4:0] r;
    r = 5'h00;
    if ((a >> 8) == '0) begin
      case (a[7:0])
        gcbf_pkg::OFF_PAUSE_FILTER_COUNT: r = {1'b1, gcbf_pkg::IDX_PAUSE};
        gcbf_pkg::OFF_IO_PERMISSION_MAP_BASE: r = {1'b1, gcbf_pkg::IDX_IOMAP};
        gcbf_pkg::OFF_MSR_PERMISSION_MAP_BASE: r = {1'b1, gcbf_pkg::IDX_MSRMAP};
        gcbf_pkg::OFF_TIMESTAMP_OFFSET: r = {1'b1, gcbf_pkg::IDX_TSOFF};
        gcbf_pkg::OFF_SPACE_TAG_AND_FLUSH_CTL: r = {1'b1, gcbf_pkg::IDX_FLUSH};
        gcbf_pkg::OFF_VIRTUAL_INTERRUPT_CTL: r = {1'b1, gcbf_pkg::IDX_VINT};
        gcbf_pkg::OFF_INTERRUPT_SHADOW_STATE: r = {1'b1, gcbf_pkg::IDX_SHADOW};
        gcbf_pkg::OFF_EXIT_REASON: r = {1'b1, gcbf_pkg::IDX_EXIT_REASON};
        gcbf_pkg::OFF_EXIT_INFO_FIRST: r = {1'b1, gcbf_pkg::IDX_EXIT_INFO1};
        gcbf_pkg::OFF_EXIT_INFO_SECOND: r = {1'b1, gcbf_pkg::IDX_EXIT_INFO2};
        gcbf_pkg::OFF_EXIT_PENDING_EVENT_INFO: r = {1'b1, gcbf_pkg::IDX_EXIT_PEND};
        gcbf_pkg::OFF_NESTED_PAGING_AND_CRYPT_CTL: r = {1'b1, gcbf_pkg::IDX_NPCTL};
        default: r = 5'h00;
      endcase
    end
    return r;
  endfunction : gcbf_decode

  localparam logic [63:0] MASKS [gcbf_pkg::NUM_REGS] = '{
    gcbf_pkg::MASK_PAUSE, gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_FULL,
    gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_FLUSH, gcbf_pkg::MASK_VINT,
    gcbf_pkg::MASK_SHADOW, gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_FULL,
    gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_NPCTL};

  logic [63:0] regs [gcbf_pkg::NUM_REGS];
  gcbf_pkg::gcbf_state_t state;
  logic [4:0] wr_dec;
  logic [4:0] rd_dec;
  logic entry_ok;
  logic exit_ok;
  logic [63:0] vint_reg;
  logic [63:0] flush_reg;
  logic [7:0] flush_code;
  logic accel_on;

  assign wr_dec = gcbf_decode(reg_addr_in);
  assign rd_dec = gcbf_decode(reg_addr_in);
  assign entry_ok = guest_entry_in && (state == gcbf_pkg::GCBF_HOST);
  assign exit_ok = guest_exit_in && (state == gcbf_pkg::GCBF_GUEST);
  assign vint_reg = regs[gcbf_pkg::IDX_VINT];
  assign flush_reg = regs[gcbf_pkg::IDX_FLUSH];
  assign flush_code = flush_reg[gcbf_pkg::FLUSH_LSB +: 8];
  assign accel_on = vint_reg[gcbf_pkg::ACCEL_BIT];

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Exit write-back wins over a software write in the same cycle so
  // that the core's state is never lost.
  generate
    for (genvar i = 0; i < gcbf_pkg::NUM_REGS; i++) begin : g_reg
      logic [63:0] next_val;
      always_comb begin
        next_val = regs[i];
        if (reg_wr_in && wr_dec[4] && (wr_dec[3:0] == 4'(i))) begin
          next_val = reg_wdata_in & MASKS[i];
        end
        if (exit_ok) begin
          case (4'(i))
            gcbf_pkg::IDX_EXIT_REASON: next_val = exit_rec_in.reason;
            gcbf_pkg::IDX_EXIT_INFO1: next_val = exit_rec_in.info_first;
            gcbf_pkg::IDX_EXIT_INFO2: next_val = exit_rec_in.info_second;
            gcbf_pkg::IDX_EXIT_PEND: next_val = exit_rec_in.pending_event;
            gcbf_pkg::IDX_VINT: begin
              next_val[gcbf_pkg::VTPR_LSB +: 4] = exit_rec_in.vtpr;
              next_val[gcbf_pkg::VIRQ_BIT] = exit_rec_in.virq;
            end
            gcbf_pkg::IDX_SHADOW: next_val[gcbf_pkg::SHADOW_BIT] = exit_rec_in.shadow;
            default: next_val = next_val;
          endcase
        end
      end
      always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
          regs[i] <= gcbf_pkg::REG_RESET;
        end else begin
          regs[i] <= next_val;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in && rd_dec[4]) begin
      reg_rdata_out <= regs[rd_dec[3:0]];
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Guest state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= gcbf_pkg::GCBF_HOST;
    end else begin
      case (state)
        gcbf_pkg::GCBF_HOST: if (entry_ok) state <= gcbf_pkg::GCBF_GUEST;
        gcbf_pkg::GCBF_GUEST: if (exit_ok) state <= gcbf_pkg::GCBF_HOST;
        default: state <= gcbf_pkg::GCBF_HOST;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      guest_running_out <= 1'b0;
    end else begin
      guest_running_out <= (state == gcbf_pkg::GCBF_GUEST) ? !exit_ok : entry_ok;
    end
  end

  // ----------------------------------------------------------------
  // Timestamp
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ts_value_out <= '0;
      ts_valid_out <= 1'b0;
    end else begin
      ts_valid_out <= ts_read_in;
      if (ts_read_in) begin
        ts_value_out <= (state == gcbf_pkg::GCBF_GUEST) ?
          ts_counter_in + regs[gcbf_pkg::IDX_TSOFF] : ts_counter_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Entry latching
  // ----------------------------------------------------------------
  // Control fields other than the timestamp offset are sampled once at entry;
  // software edits to them during a guest run take effect on the next entry only.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      io_permission_map_out <= '0;
      msr_permission_map_out <= '0;
      nested_paging_on_out <= 1'b0;
      crypt_on_out <= 1'b0;
      pause_count_out <= '0;
      shadow_out <= 1'b0;
    end else if (entry_ok) begin
      io_permission_map_out <= {regs[gcbf_pkg::IDX_IOMAP][63:gcbf_pkg::MAP_DROP_BITS],
                                12'h000};
      msr_permission_map_out <= {regs[gcbf_pkg::IDX_MSRMAP][63:gcbf_pkg::MAP_DROP_BITS],
                                 12'h000};
      nested_paging_on_out <= regs[gcbf_pkg::IDX_NPCTL][gcbf_pkg::NESTED_BIT];
      crypt_on_out <= regs[gcbf_pkg::IDX_NPCTL][gcbf_pkg::CRYPT_BIT];
      pause_count_out <= regs[gcbf_pkg::IDX_PAUSE][15:0];
      shadow_out <= regs[gcbf_pkg::IDX_SHADOW][gcbf_pkg::SHADOW_BIT];
    end
  end

  // Flush request is a one-cycle pulse after entry; reserved codes
  // flush nothing.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      flush_out <= '0;
    end else begin
      flush_out.all <= entry_ok && (flush_code == gcbf_pkg::FLUSH_ALL);
      flush_out.guest <= entry_ok && (flush_code == gcbf_pkg::FLUSH_GUEST);
      flush_out.nonglobal <= entry_ok && (flush_code == gcbf_pkg::FLUSH_NONGLOBAL);
      if (entry_ok) begin
        flush_out.tag <= flush_reg[gcbf_pkg::TAG_MSB:0];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      vint_out <= '0;
    end else if (entry_ok) begin
      vint_out.vtpr <= vint_reg[gcbf_pkg::VTPR_LSB +: 4];
      vint_out.pending <= !accel_on && vint_reg[gcbf_pkg::VIRQ_BIT];
      vint_out.prio <= accel_on ? 4'h0 : vint_reg[gcbf_pkg::PRIO_LSB +: 4];
      vint_out.ign_tpr <= !accel_on && vint_reg[gcbf_pkg::IGN_TPR_BIT];
      vint_out.vector <= accel_on ? 8'h00 : vint_reg[gcbf_pkg::VECTOR_LSB +: 8];
      vint_out.virtual_global_int_flag_value <= vint_reg[gcbf_pkg::VIRTUAL_GLOBAL_INT_FLAG_VALUE_BIT];
      vint_out.virtual_global_int_flag_en <= vint_reg[gcbf_pkg::VIRTUAL_GLOBAL_INT_FLAG_EN_BIT];
      vint_out.masking <= vint_reg[gcbf_pkg::MASKING_BIT];
      vint_out.accel <= accel_on;
    end
  end

  // ----------------------------------------------------------------
  // Delivery decision
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      vint_deliver_out <= 1'b0;
    end else begin
      vint_deliver_out <= guest_running_out && !exit_ok && vint_out.pending &&
        (!vint_out.virtual_global_int_flag_en || vint_out.virtual_global_int_flag_value) &&
        (vint_out.ign_tpr || (vint_out.prio > vint_out.vtpr));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_iomap_low;
    $rose(guest_running_out) |-> io_permission_map_out[11:0] == 12'h000;
  endproperty
  a_iomap_low: assert property (p_iomap_low) else $error("io map low bits kept");

  property p_msrmap;
    entry_ok |=> msr_permission_map_out[63:12] == $past(regs[gcbf_pkg::IDX_MSRMAP][63:12]);
  endproperty
  a_msrmap: assert property (p_msrmap) else $error("msr map base wrong");

  property p_ts;
    ts_read_in && state == gcbf_pkg::GCBF_GUEST |=> ts_valid_out &&
      ts_value_out == $past(ts_counter_in) + $past(regs[gcbf_pkg::IDX_TSOFF]);
  endproperty
  a_ts: assert property (p_ts) else $error("timestamp offset not added");

  property p_no_flush;
    entry_ok && flush_code == gcbf_pkg::FLUSH_NONE |=> !flush_out.all &&
      !flush_out.guest && !flush_out.nonglobal;
  endproperty
  a_no_flush: assert property (p_no_flush) else $error("flush on code 00h");

  property p_flush_all;
    entry_ok && flush_code == gcbf_pkg::FLUSH_ALL |=> flush_out.all ##1 !flush_out.all;
  endproperty
  a_flush_all: assert property (p_flush_all) else $error("flush all pulse wrong");

  property p_flush_guest;
    entry_ok && flush_code == gcbf_pkg::FLUSH_GUEST |=> flush_out.guest &&
      flush_out.tag == $past(flush_reg[31:0]);
  endproperty
  a_flush_guest: assert property (p_flush_guest) else $error("guest flush wrong");

  property p_flush_ng;
    entry_ok && flush_code == gcbf_pkg::FLUSH_NONGLOBAL |=> flush_out.nonglobal && !flush_out.all;
  endproperty
  a_flush_ng: assert property (p_flush_ng) else $error("nonglobal flush wrong");

  property p_vtpr_back;
    exit_ok |=> regs[gcbf_pkg::IDX_VINT][3:0] == $past(exit_rec_in.vtpr);
  endproperty
  a_vtpr_back: assert property (p_vtpr_back) else $error("task priority not written back");

  property p_accel_ignore;
    entry_ok && accel_on |=> !vint_out.pending && vint_out.vector == 8'h00;
  endproperty
  a_accel_ignore: assert property (p_accel_ignore) else $error("accel mode not ignored");

  property p_exit_rec;
    exit_ok |=> regs[gcbf_pkg::IDX_EXIT_REASON] == $past(exit_rec_in.reason) &&
      regs[gcbf_pkg::IDX_EXIT_PEND] == $past(exit_rec_in.pending_event);
  endproperty
  a_exit_rec: assert property (p_exit_rec) else $error("exit record lost");

  property p_masked;
    vint_out.virtual_global_int_flag_en && !vint_out.virtual_global_int_flag_value |=> !vint_deliver_out;
  endproperty
  a_masked: assert property (p_masked) else $error("delivered while masked");

  property p_prio;
    entry_ok && !accel_on |=> vint_out.prio == $past(vint_reg[gcbf_pkg::PRIO_LSB +: 4]);
  endproperty
  a_prio: assert property (p_prio) else $error("interrupt priority not taken");

  property p_vector;
    entry_ok && !accel_on |=> vint_out.vector == $past(vint_reg[gcbf_pkg::VECTOR_LSB +: 8]);
  endproperty
  a_vector: assert property (p_vector) else $error("interrupt vector not taken");

  property p_ign_tpr;
    guest_running_out && !exit_ok && vint_out.pending && vint_out.ign_tpr &&
      (!vint_out.virtual_global_int_flag_en || vint_out.virtual_global_int_flag_value) |=> vint_deliver_out;
  endproperty
  a_ign_tpr: assert property (p_ign_tpr) else $error("threshold not skipped");

  property p_virtual_global_int_flag_en;
    entry_ok |=> vint_out.virtual_global_int_flag_en == $past(vint_reg[gcbf_pkg::VIRTUAL_GLOBAL_INT_FLAG_EN_BIT]);
  endproperty
  a_virtual_global_int_flag_en: assert property (p_virtual_global_int_flag_en) else $error("flag enable not taken");

  property p_masking;
    entry_ok |=> vint_out.masking == $past(vint_reg[gcbf_pkg::MASKING_BIT]);
  endproperty
  a_masking: assert property (p_masking) else $error("masking bit not taken");

  property p_shadow;
    entry_ok |=> shadow_out == $past(regs[gcbf_pkg::IDX_SHADOW][gcbf_pkg::SHADOW_BIT]);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow bit not taken");

  property p_crypt;
    entry_ok |=> crypt_on_out == $past(regs[gcbf_pkg::IDX_NPCTL][gcbf_pkg::CRYPT_BIT]);
  endproperty
  a_crypt: assert property (p_crypt) else $error("encryption enable not taken");

  property p_nested;
    entry_ok |=> nested_paging_on_out == $past(regs[gcbf_pkg::IDX_NPCTL][gcbf_pkg::NESTED_BIT]);
  endproperty
  a_nested: assert property (p_nested) else $error("nested paging enable not taken");

  c_entry_exit: cover property (entry_ok ##[1:20] exit_ok);
  c_deliver: cover property (vint_deliver_out);
  c_flush_guest: cover property (flush_out.guest);
  c_ts_guest: cover property (ts_valid_out && guest_running_out);
  c_flush_all: cover property (flush_out.all);

endmodule : gcbf_guest_control_block_fields

//--- gcbf_pkg.sv
package gcbf_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PAUSE_FILTER_COUNT = 8'h3E;
  localparam logic [7:0] OFF_IO_PERMISSION_MAP_BASE = 8'h40;
  localparam logic [7:0] OFF_MSR_PERMISSION_MAP_BASE = 8'h48;
  localparam logic [7:0] OFF_TIMESTAMP_OFFSET = 8'h50;
  localparam logic [7:0] OFF_SPACE_TAG_AND_FLUSH_CTL = 8'h58;
  localparam logic [7:0] OFF_VIRTUAL_INTERRUPT_CTL = 8'h60;
  localparam logic [7:0] OFF_INTERRUPT_SHADOW_STATE = 8'h68;
  localparam logic [7:0] OFF_EXIT_REASON = 8'h70;
  localparam logic [7:0] OFF_EXIT_INFO_FIRST = 8'h78;
  localparam logic [7:0] OFF_EXIT_INFO_SECOND = 8'h80;
  localparam logic [7:0] OFF_EXIT_PENDING_EVENT_INFO = 8'h88;
  localparam logic [7:0] OFF_NESTED_PAGING_AND_CRYPT_CTL = 8'h90;

  // ----------------------------------------------------------------
  // Register indices in the storage array
  // ----------------------------------------------------------------
  localparam int unsigned NUM_REGS = 12;
  localparam logic [3:0] IDX_PAUSE = 4'h0;
  localparam logic [3:0] IDX_IOMAP = 4'h1;
  localparam logic [3:0] IDX_MSRMAP = 4'h2;
  localparam logic [3:0] IDX_TSOFF = 4'h3;
  localparam logic [3:0] IDX_FLUSH = 4'h4;
  localparam logic [3:0] IDX_VINT = 4'h5;
  localparam logic [3:0] IDX_SHADOW = 4'h6;
  localparam logic [3:0] IDX_EXIT_REASON = 4'h7;
  localparam logic [3:0] IDX_EXIT_INFO1 = 4'h8;
  localparam logic [3:0] IDX_EXIT_INFO2 = 4'h9;
  localparam logic [3:0] IDX_EXIT_PEND = 4'hA;
  localparam logic [3:0] IDX_NPCTL = 4'hB;

  // ----------------------------------------------------------------
  // Storage masks: reserved bits are not stored and read as zero
  // ----------------------------------------------------------------
  localparam logic [63:0] MASK_PAUSE = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] MASK_FULL = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] MASK_FLUSH = 64'h0000_00FF_FFFF_FFFF;
  localparam logic [63:0] MASK_VINT = 64'h0000_00FF_831F_030F;
  localparam logic [63:0] MASK_SHADOW = 64'h0000_0000_0000_0001;
  localparam logic [63:0] MASK_NPCTL = 64'h0000_0000_0000_0003;
  localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned MAP_DROP_BITS = 12;
  localparam int unsigned TAG_MSB = 31;
  localparam int unsigned FLUSH_LSB = 32;
  localparam int unsigned VTPR_LSB = 0;
  localparam int unsigned VIRQ_BIT = 8;
  localparam int unsigned VIRTUAL_GLOBAL_INT_FLAG_VALUE_BIT = 9;
  localparam int unsigned PRIO_LSB = 16;
  localparam int unsigned IGN_TPR_BIT = 20;
  localparam int unsigned MASKING_BIT = 24;
  localparam int unsigned VIRTUAL_GLOBAL_INT_FLAG_EN_BIT = 25;
  localparam int unsigned ACCEL_BIT = 31;
  localparam int unsigned VECTOR_LSB = 32;
  localparam int unsigned SHADOW_BIT = 0;
  localparam int unsigned NESTED_BIT = 0;
  localparam int unsigned CRYPT_BIT = 1;

  // ----------------------------------------------------------------
  // Flush control encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] FLUSH_NONE = 8'h00;
  localparam logic [7:0] FLUSH_ALL = 8'h01;
  localparam logic [7:0] FLUSH_GUEST = 8'h03;
  localparam logic [7:0] FLUSH_NONGLOBAL = 8'h07;

  typedef enum logic [1:0] {
    GCBF_HOST = 2'h1,
    GCBF_GUEST = 2'h2
  } gcbf_state_t;

  // State handed back by the core on a guest exit
  typedef struct packed {
    logic [63:0] reason;
    logic [63:0] info_first;
    logic [63:0] info_second;
    logic [63:0] pending_event;
    logic [3:0] vtpr;
    logic virq;
    logic shadow;
  } gcbf_exit_rec_t;

  // Virtual interrupt state latched at guest entry
  typedef struct packed {
    logic pending;
    logic [3:0] prio;
    logic ign_tpr;
    logic [7:0] vector;
    logic [3:0] vtpr;
    logic virtual_global_int_flag_value;
    logic virtual_global_int_flag_en;
    logic masking;
    logic accel;
  } gcbf_vint_t;

  // Flush request issued at guest entry
  typedef struct packed {
    logic all;
    logic guest;
    logic nonglobal;
    logic [31:0] tag;
  } gcbf_flush_t;

endpackage : gcbf_pkg

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic core_clk_in;
  logic sys_rst_in;
  logic [7:0] reg_addr_in;
  logic [63:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [63:0] reg_rdata_out;
  logic guest_entry_in;
  logic guest_exit_in;
  gcbf_pkg::gcbf_exit_rec_t exit_rec_in;
  logic ts_read_in;
  logic [63:0] ts_counter_in;
  logic [63:0] ts_value_out;
  logic ts_valid_out;
  logic guest_running_out;
  logic [63:0] io_permission_map_out;
  logic [63:0] msr_permission_map_out;
  gcbf_pkg::gcbf_flush_t flush_out;
  gcbf_pkg::gcbf_vint_t vint_out;
  logic vint_deliver_out;
  logic shadow_out;
  logic nested_paging_on_out;
  logic crypt_on_out;
  logic [15:0] pause_count_out;
  int n_errors;
  int cmp_count;
  int cycles;

  gcbf_guest_control_block_fields dut (
    .core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .guest_entry_in, .guest_exit_in, .exit_rec_in, .ts_read_in,
    .ts_counter_in, .ts_value_out, .ts_valid_out, .guest_running_out,
    .io_permission_map_out, .msr_permission_map_out, .flush_out, .vint_out,
    .vint_deliver_out, .shadow_out, .nested_paging_on_out, .crypt_on_out, .pause_count_out
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  // The whole run needs well under a thousand cycles
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [63:0] exp);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 check(reg_rdata_out, exp);
  endtask : rdchk

  task automatic enter();
    @(posedge core_clk_in);
    guest_entry_in <= 1'b1;
    @(posedge core_clk_in);
    guest_entry_in <= 1'b0;
    #1;
  endtask : enter

  task automatic leave(input gcbf_pkg::gcbf_exit_rec_t r);
    @(posedge core_clk_in);
    guest_exit_in <= 1'b1;
    exit_rec_in <= r;
    @(posedge core_clk_in);
    guest_exit_in <= 1'b0;
    #1;
  endtask : leave

  task automatic tscheck(input logic [63:0] c, input logic [63:0] exp);
    @(posedge core_clk_in);
    ts_read_in <= 1'b1;
    ts_counter_in <= c;
    @(posedge core_clk_in);
    ts_read_in <= 1'b0;
    #1 check(64'(ts_valid_out), 64'h1);
    check(ts_value_out, exp);
  endtask : tscheck

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] offs [12] = '{8'h3E, 8'h40, 8'h48, 8'h50, 8'h58, 8'h60, 8'h68, 8'h70,
      8'h78, 8'h80, 8'h88, 8'h90};
    logic [63:0] msk [12] = '{gcbf_pkg::MASK_PAUSE, gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_FULL,
      gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_FLUSH, gcbf_pkg::MASK_VINT, gcbf_pkg::MASK_SHADOW,
      gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_FULL, gcbf_pkg::MASK_FULL,
      gcbf_pkg::MASK_NPCTL};
    logic [63:0] wv;
    for (int i = 0; i < 12; i++) begin
      // Reserved bits stay zero and only a defined flush code is written
      wv = (i == 4) ? 64'h0000_0007_FFFF_FFFF : msk[i];
      rdchk(offs[i], 64'h0);
      wr(offs[i], wv);
      rdchk(offs[i], wv & msk[i]);
    end
    wr(8'h44, gcbf_pkg::MASK_FULL);
    rdchk(8'h44, 64'h0);
    rdchk(8'h90, 64'h3);
    @(posedge core_clk_in);
    #1 check(reg_rdata_out, 64'h0);
  endtask : t_regs

  task automatic t_maps();
    wr(8'h40, 64'hFEDC_BA98_7654_3FFF);
    wr(8'h48, 64'h0123_4567_89AB_CDEF);
    wr(8'h3E, 64'h0000_0000_0000_A5C3);
    wr(8'h68, 64'h1);
    wr(8'h90, 64'h2);
    wr(8'h50, 64'h0000_0001_0000_0010);
    tscheck(64'h0000_0000_0000_0100, 64'h0000_0000_0000_0100);
    enter();
    check(64'(guest_running_out), 64'h1);
    check(io_permission_map_out, 64'hFEDC_BA98_7654_3000);
    check(msr_permission_map_out, 64'h0123_4567_89AB_C000);
    check(64'(pause_count_out), 64'hA5C3);
    check(64'(shadow_out), 64'h1);
    check(64'(nested_paging_on_out), 64'h0);
    check(64'(crypt_on_out), 64'h1);
    tscheck(64'hFFFF_FFFF_FFFF_FFF8, 64'h0000_0001_0000_0008);
    leave('0);
    wr(8'h90, 64'h1);
    enter();
    check(64'(nested_paging_on_out), 64'h1);
    check(64'(crypt_on_out), 64'h0);
    leave('0);
  endtask : t_maps

  // Only defined codes are written; a second entry while running is ignored
  task automatic t_flush();
    logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h03};
    gcbf_pkg::gcbf_flush_t e;
    for (int i = 0; i < 5; i++) begin
      e = '{codes[i] == 8'h01, codes[i] == 8'h03, codes[i] == 8'h07, 32'hC0DE_0010 | 32'(i)};
      wr(8'h58, {24'h0, codes[i], e.tag});
      enter();
      check(64'(flush_out), 64'(e));
      e = '{1'b0, 1'b0, 1'b0, e.tag};
      enter();
      check(64'(flush_out), 64'(e));
      leave('0);
    end
  endtask : t_flush

  task automatic t_vint();
    logic [63:0] w [6] = '{64'h0000_0047_0105_0103, 64'h0000_0047_0003_0103,
      64'h0000_0047_0013_0103, 64'h0000_0047_0205_0103, 64'h0000_0047_0205_0303,
      64'h0000_0047_8015_0103};
    gcbf_pkg::gcbf_vint_t e;
    gcbf_pkg::gcbf_exit_rec_t r;
    logic dl;
    logic [63:0] wb;
    for (int i = 0; i < 6; i++) begin
      wr(8'h60, w[i]);
      enter();
      e.accel = w[i][31];
      e.pending = w[i][8] & ~e.accel;
      e.prio = e.accel ? 4'h0 : w[i][19:16];
      e.ign_tpr = w[i][20] & ~e.accel;
      e.vector = e.accel ? 8'h00 : w[i][39:32];
      e.vtpr = w[i][3:0];
      e.virtual_global_int_flag_value = w[i][9];
      e.virtual_global_int_flag_en = w[i][25];
      e.masking = w[i][24];
      dl = e.pending & (~e.virtual_global_int_flag_en | e.virtual_global_int_flag_value) & (e.ign_tpr | (e.prio > e.vtpr));
      check(64'(vint_out), 64'(e));
      @(posedge core_clk_in);
      #1 check(64'(vint_deliver_out), 64'(dl));
      r = '{64'hE000_0000_0000_0000 | 64'(i), 64'h1111_2222_3333_4444 ^ 64'(i),
        64'h8000_0000_0000_0001, 64'h0000_7777_0000_0000 | 64'(i), 4'(9 + i), i[0], ~i[0]};
      leave(r);
      check(64'(vint_deliver_out), 64'h0);
      wb = w[i] & gcbf_pkg::MASK_VINT;
      wb[3:0] = r.vtpr;
      wb[8] = r.virq;
      rdchk(8'h60, wb);
      rdchk(8'h68, 64'(r.shadow));
      rdchk(8'h70, r.reason);
      rdchk(8'h78, r.info_first);
      rdchk(8'h80, r.info_second);
      rdchk(8'h88, r.pending_event);
    end
  endtask : t_vint

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    sys_rst_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 64'h0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    guest_entry_in = 1'b0;
    guest_exit_in = 1'b0;
    exit_rec_in = '0;
    ts_read_in = 1'b0;
    ts_counter_in = 64'h0;
    repeat (8) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_maps();
    t_flush();
    t_vint();
    give_verdict();
  end
endmodule : tb_top
